// File: logic/lpm_pkg.sv
// Overview of operation
// [RL1] three regulator ranges cap cpu clock frequency
// [RL2] sleep halts cpu clock only, events wake
// [RL3] low-power run needs slow multispeed clock
// [RL4] sleep with low-power regulator gives low-power sleep
// [RL5] low-power sleep wake returns to normal run
// [RL6] stop with clock keeps only low-speed oscillators
// [RL7] stop without clock stops every oscillator
// [RL8] stop keeps ram and register contents
// [RL9] peripheral may borrow fast rc during stop
// [RL10] event line wakes stop within 3.5 us
// [RL11] stop with clock accepts gpio, clock, serial
// [RL12] stop without clock accepts gpio and serial
// [RL13] standby switches regulator and core power off
// [RL14] standby loses ram, keeps standby circuitry
// [RL15] standby exit within 60 us on wake source
// [RL16] far side wakes standby by pin rising edge
// [RL17] fast external clock is bypass input only
// [RL18] stop or standby keeps clock and watchdog sources; code turns lsi and lse off in stop and standby without clock
// [RL19] low supply: step under four, 5 us apart
// [RL20] standby exit restarts core by full reset
// [RL21] enter only on sleep request, mask wakes
//
// Purpose: constants and types of the low-power mode controller
// Assumes: 100 MHz controller clock
// Notes:   frequencies in kHz, times in ns
package lpm_pkg;
   localparam int CLK_PERIOD_NS = 10;          // controller clock period
   localparam int STOP_WAKE_NS  = 3500;        // longest stop wake time
   localparam int STBY_EXIT_NS  = 60000;       // longest standby exit time
   localparam int FREQ_GAP_NS   = 5000;        // least gap between steps
   // longest times round down, least times round up
   localparam int STOP_WAKE_CYC = STOP_WAKE_NS / CLK_PERIOD_NS;
   localparam int STBY_EXIT_CYC = STBY_EXIT_NS / CLK_PERIOD_NS;
   localparam int FREQ_GAP_CYC  = (FREQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STOP_RESTART_CYC = 16;       // oscillator restart after stop
   localparam int CNT_W = 13;                  // holds the standby count
   localparam int GAP_W = 10;                  // holds the step gap count
   // frequency limits in kHz
   localparam logic [15:0] LIM_RANGE1 = 16'h7D00;   // 32000
   localparam logic [15:0] LIM_RANGE2 = 16'h3E80;   // 16000
   localparam logic [15:0] LIM_RANGE3 = 16'h1068;   // 4200
   localparam logic [15:0] LIM_LPRUN  = 16'h0083;   // 131
   localparam logic [15:0] FREQ_RST   = 16'h07D0;   // 2000 after reset
   // low-power mode selections
   localparam logic [2:0] MODE_SLEEP     = 3'h0;
   localparam logic [2:0] MODE_STOP_RTC  = 3'h1;
   localparam logic [2:0] MODE_STOP      = 3'h2;
   localparam logic [2:0] MODE_STBY_RTC  = 3'h3;
   localparam logic [2:0] MODE_STBY      = 3'h4;
   // controller states, gray along run-sleep-stop-wake
   typedef enum logic [2:0] {
      ST_RUN   = 3'h0,
      ST_SLEEP = 3'h1,
      ST_STOP  = 3'h3,
      ST_WAKE  = 3'h2,
      ST_STBY  = 3'h6,
      ST_BOOT  = 3'h7,
      ST_LPSLP = 3'h5
   } lpm_state_t;
endpackage

// File: logic/lp_mode_ctrl.sv
// Purpose: sequences run, sleep, stop and standby of the core domain
// Assumes: pin events are asynchronous, cpu and peripheral strobes are on CLK
// Notes:   all outputs are flip-flops updated from the next state
`timescale 1ns/1ps
module lp_mode_ctrl #(
   parameter int STBY_BOOT_CYC = lpm_pkg::STBY_EXIT_CYC    // core reset span
) (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        SLEEP_REQ,       // cpu sleep request pulse
   input  wire logic [2:0]  MODE_SEL,        // lpm_pkg::MODE_* selection
   input  wire logic        PERIPH_EVT,      // peripheral interrupt or event
   input  wire logic        LP_RUN_REQ,      // pulse: enter low-power run
   input  wire logic        LP_RUN_EXIT,     // pulse: leave low-power run
   input  wire logic        MSI_LOW,         // multispeed_rc_osc at low speed
   input  wire logic [1:0]  RANGE_SEL,       // regulator range 1..3
   input  wire logic [1:0]  LS_OSC_ON,       // {lse, lsi} enabled by software
   input  wire logic        LOW_SUPPLY,      // supply in low band
   input  wire logic        FREQ_REQ,        // pulse: frequency step
   input  wire logic [15:0] FREQ_NEW,        // requested frequency, kHz
   input  wire logic        EVT_GPIO,        // external_event_line from gpio
   input  wire logic [3:0]  EVT_RTC,         // alarm, tamper, stamp, periodic
   input  wire logic [3:0]  EVT_SER,         // usart, i2c, uart, timer wakes
   input  wire logic [2:0]  WAKE_PIN,        // standby_wake_pin inputs
   input  wire logic        EXT_RST_N,       // external_reset_pin, low active
   input  wire logic        WDG_RESET,       // independent_watchdog reset
   input  wire logic        HSI_REQ,         // peripheral asks for fast rc
   output logic             CPU_CLK_EN,
   output logic             PERIPH_CLK_EN,
   output logic             PLL_EN,
   output logic             MSI_EN,
   output logic             HSI_EN,
   output logic             HSE_BYP_EN,
   output logic             LSI_EN,
   output logic             LSE_EN,
   output logic             REG_LP,
   output logic             REG_OFF,
   output logic             CORE_PWR_EN,
   output logic             RETAIN_EN,
   output logic             STBY_KEEP,
   output logic             CORE_RESET,
   output logic             WAKE_IRQ,
   output logic             LP_RUN_ACT,
   output logic [15:0]      FREQ_LIMIT_KHZ,
   output logic [15:0]      FREQ_KHZ,
   output logic             FREQ_ACK,
   output logic             FREQ_NAK,
   output lpm_pkg::lpm_state_t STATE
);
   import lpm_pkg::*;

   // pin inputs, two flops before use
   logic [14:0] pin_raw;                   // gathered asynchronous pins
   logic [14:0] sync1_reg;                 // first stage, read only by stage two
   logic [14:0] sync2_reg;                 // usable synchronised copy
   logic [2:0]  pin_prev_reg;              // wake pins one cycle back
   assign pin_raw = {HSI_REQ, WDG_RESET, ~EXT_RST_N, WAKE_PIN,
                     EVT_SER, EVT_RTC, EVT_GPIO};

   // two-flop synchroniser
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         sync1_reg <= 15'h0000;
         sync2_reg <= 15'h0000;
      end else begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
      end
   end

   // wake pin history for edge detection
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) pin_prev_reg <= 3'h0;
      else     pin_prev_reg <= sync2_reg[11:9];
   end

   // named views of the synchronised pins
   logic       gpio_s;                     // gpio event line
   logic [3:0] rtc_s;                      // clock events
   logic [3:0] ser_s;                      // serial and timer wakes
   logic [2:0] pin_s;                      // wake pin levels
   logic       xrst_s;                     // external reset asserted
   logic       wdg_s;                      // watchdog reset
   logic       hsi_req_s;                  // fast rc request
   assign gpio_s    = sync2_reg[0];
   assign rtc_s     = sync2_reg[4:1];
   assign ser_s     = sync2_reg[8:5];
   assign pin_s     = sync2_reg[11:9];
   assign xrst_s    = sync2_reg[12];
   assign wdg_s     = sync2_reg[13];
   assign hsi_req_s = sync2_reg[14];

   // state, mode and counters
   lpm_state_t  state_reg, state_next;     // sequencer state
   logic [2:0]  mode_reg, mode_next;       // mode latched at entry
   logic [CNT_W-1:0] cnt_reg, cnt_next;    // wake and boot delay
   logic        lprun_reg, lprun_next;     // low-power run active
   logic [15:0] freq_reg, freq_next;       // current cpu frequency
   logic [GAP_W-1:0] gap_reg, gap_next;    // cycles left before next step

   // mode classification, used in several places
   function automatic logic is_rtc(input logic [2:0] m);
      is_rtc = (m == MODE_STOP_RTC) || (m == MODE_STBY_RTC);
   endfunction
   function automatic logic is_stop(input logic [2:0] m);
      is_stop = (m == MODE_STOP_RTC) || (m == MODE_STOP);
   endfunction

   // wake qualification; invalid sources are simply ignored
   logic sleep_go;                         // cpu asked to sleep in run
   logic wake_stop;                        // valid stop wake
   logic wake_stby;                        // valid standby wake
   logic pin_rise;                         // rising edge on a wake pin
   logic boot_done;                        // delay counter expired
   assign pin_rise = |(pin_s & ~pin_prev_reg);
   assign sleep_go = SLEEP_REQ && (state_reg == ST_RUN);
   // [RL11] [RL12] per-mode stop wake masks
   assign wake_stop = gpio_s || (|ser_s) || (is_rtc(mode_reg) && (|rtc_s));
   // [RL15] [RL16] standby wake sources
   assign wake_stby = xrst_s || wdg_s || pin_rise ||
                      ((mode_reg == MODE_STBY_RTC) && (|rtc_s));
   assign boot_done = (cnt_reg == '0);

   // next-state sequencing
   always_comb begin
      state_next = state_reg;
      mode_next  = mode_reg;
      cnt_next   = boot_done ? cnt_reg : cnt_reg - 1'b1;
      unique case (state_reg)
         ST_RUN: begin
            // [RL21] leave run only on a sleep request
            if (sleep_go) begin
               mode_next = MODE_SEL;
               if (MODE_SEL == MODE_SLEEP)
                  // [RL4] regulator setting picks sleep flavour
                  state_next = lprun_reg ? ST_LPSLP : ST_SLEEP;
               else if (is_stop(MODE_SEL))
                  state_next = ST_STOP;
               else
                  state_next = ST_STBY;
            end
         end
         // [RL2] any peripheral event wakes sleep
         ST_SLEEP:  if (PERIPH_EVT) state_next = ST_RUN;
         // [RL5] back to run with normal regulator
         ST_LPSLP:  if (PERIPH_EVT) state_next = ST_RUN;
         ST_STOP: begin
            // [RL10] restart delay well inside the wake bound
            if (wake_stop) begin
               state_next = ST_WAKE;
               cnt_next   = CNT_W'(STOP_RESTART_CYC - 1);
            end
         end
         ST_WAKE:   if (boot_done) state_next = ST_RUN;
         ST_STBY: begin
            // [RL20] core restarts through reset, no resume
            if (wake_stby) begin
               state_next = ST_BOOT;
               cnt_next   = CNT_W'(STBY_BOOT_CYC - 1);
            end
         end
         ST_BOOT:   if (boot_done) state_next = ST_RUN;
         default:   state_next = ST_RUN;
      endcase
   end

   // low-power run flag
   logic lprun_ok;                         // multispeed clock slow enough
   assign lprun_ok = MSI_LOW && (freq_reg <= LIM_LPRUN);
   always_comb begin
      lprun_next = lprun_reg;
      // [RL3] low-power run only on the slow clock
      if (state_reg == ST_RUN && LP_RUN_REQ && lprun_ok)
         lprun_next = 1'b1;
      if (LP_RUN_EXIT || !MSI_LOW)
         lprun_next = 1'b0;
      // [RL5] wake from low-power sleep drops low-power run
      if (state_reg == ST_LPSLP && state_next == ST_RUN)
         lprun_next = 1'b0;
      if (state_next == ST_BOOT)
         lprun_next = 1'b0;
   end

   // frequency limit from range or low-power run
   logic [15:0] limit_next;                // next frequency ceiling
   // [RL1] range to ceiling
   assign limit_next = lprun_next        ? LIM_LPRUN  :
                       (RANGE_SEL == 2'h1) ? LIM_RANGE1 :
                       (RANGE_SEL == 2'h2) ? LIM_RANGE2 : LIM_RANGE3;

   // frequency step checks
   logic        step_ok;                   // request may be taken
   logic        ratio_ok;                  // step under factor four
   logic [17:0] new_w;                     // request widened
   logic [17:0] cur_x4;                    // four times current
   assign new_w    = {2'b00, FREQ_NEW};
   assign cur_x4   = {freq_reg, 2'b00};
   // [RL19] factor four only matters on low supply
   assign ratio_ok = !LOW_SUPPLY || (new_w < cur_x4);
   assign step_ok  = (state_reg == ST_RUN) && (gap_reg == '0) && ratio_ok &&
                     (FREQ_NEW != 16'h0000) && (FREQ_NEW <= limit_next);
   always_comb begin
      freq_next = freq_reg;
      gap_next  = (gap_reg == '0) ? gap_reg : gap_reg - 1'b1;
      // [RL19] spacing enforced on every step
      if (FREQ_REQ && step_ok) begin
         freq_next = FREQ_NEW;
         gap_next  = GAP_W'(FREQ_GAP_CYC - 1);
      end
      if (state_next == ST_BOOT)
         freq_next = FREQ_RST;
   end

   // output decode from the next state
   logic in_stop, in_stby, quiet;          // next state classes
   logic rtc_keep;                         // low-speed sources may run
   logic hi_osc_next;                      // pll, msi, hse allowed
   assign in_stop  = (state_next == ST_STOP);
   assign in_stby  = (state_next == ST_STBY);
   assign quiet    = in_stop || in_stby;
   assign rtc_keep = !quiet || is_rtc(mode_next);
   // [RL6] [RL13] fast sources off in stop and standby
   assign hi_osc_next = !quiet;

   // state and housekeeping registers
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_reg <= ST_RUN;
         mode_reg  <= MODE_SLEEP;
         cnt_reg   <= '0;
         lprun_reg <= 1'b0;
         freq_reg  <= FREQ_RST;
         gap_reg   <= '0;
      end else begin
         state_reg <= state_next;
         mode_reg  <= mode_next;
         cnt_reg   <= cnt_next;
         lprun_reg <= lprun_next;
         freq_reg  <= freq_next;
         gap_reg   <= gap_next;
      end
   end

   // clock and oscillator enables
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         CPU_CLK_EN    <= 1'b1;
         PERIPH_CLK_EN <= 1'b1;
         PLL_EN        <= 1'b1;
         MSI_EN        <= 1'b1;
         HSI_EN        <= 1'b1;
         HSE_BYP_EN    <= 1'b1;
         LSI_EN        <= 1'b0;
         LSE_EN        <= 1'b0;
      end else begin
         CPU_CLK_EN    <= (state_next == ST_RUN);
         PERIPH_CLK_EN <= !quiet && (state_next != ST_BOOT);
         PLL_EN        <= hi_osc_next;
         MSI_EN        <= hi_osc_next;
         // [RL9] fast rc lent to a waking peripheral
         HSI_EN        <= hi_osc_next || (in_stop && hsi_req_s);
         // [RL17] bypass input only, no crystal driver exists
         HSE_BYP_EN    <= hi_osc_next;
         // [RL18] [RL7] software choice kept unless stop or standby without clock
         LSI_EN        <= LS_OSC_ON[0] && rtc_keep;
         LSE_EN        <= LS_OSC_ON[1] && rtc_keep;
      end
   end

   // regulator, power, retention and status
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         REG_LP         <= 1'b0;
         REG_OFF        <= 1'b0;
         CORE_PWR_EN    <= 1'b1;
         RETAIN_EN      <= 1'b0;
         STBY_KEEP      <= 1'b0;
         CORE_RESET     <= 1'b0;
         WAKE_IRQ       <= 1'b0;
         LP_RUN_ACT     <= 1'b0;
         FREQ_LIMIT_KHZ <= LIM_RANGE3;
         FREQ_KHZ       <= FREQ_RST;
         FREQ_ACK       <= 1'b0;
         FREQ_NAK       <= 1'b0;
         STATE          <= ST_RUN;
      end else begin
         // [RL4] [RL6] low-power regulator states
         REG_LP         <= in_stop || (state_next == ST_LPSLP) ||
                           ((state_next == ST_RUN) && lprun_next);
         // [RL13] regulator off, core unpowered
         REG_OFF        <= in_stby;
         CORE_PWR_EN    <= !in_stby;
         // [RL8] [RL14] retention lost only through standby
         RETAIN_EN      <= in_stop;
         STBY_KEEP      <= in_stby;
         CORE_RESET     <= (state_next == ST_BOOT);
         WAKE_IRQ       <= (state_reg == ST_WAKE) && (state_next == ST_RUN);
         LP_RUN_ACT     <= lprun_next;
         FREQ_LIMIT_KHZ <= limit_next;
         FREQ_KHZ       <= freq_next;
         FREQ_ACK       <= FREQ_REQ && step_ok;
         FREQ_NAK       <= FREQ_REQ && !step_ok;
         STATE          <= state_next;
      end
   end

   // helper: cycles since last accepted step, saturating
   logic [GAP_W-1:0] since_ack_reg;
   always_ff @(posedge CLK or posedge RST) begin
      if (RST)           since_ack_reg <= '1;
      else if (FREQ_ACK) since_ack_reg <= '0;
      else if (since_ack_reg != '1) since_ack_reg <= since_ack_reg + 1'b1;
   end

   sleep_clocks_a: assert property ( // [RL2]
      @(posedge CLK) disable iff (RST)
      (STATE == ST_SLEEP) |-> !CPU_CLK_EN && PERIPH_CLK_EN)
      else $error("sleep must gate only the cpu clock");

   stop_osc_off_a: assert property ( // [RL6]
      @(posedge CLK) disable iff (RST)
      (STATE == ST_STOP) |-> !PLL_EN && !MSI_EN && !HSE_BYP_EN && REG_LP)
      else $error("fast sources running in stop");

   stop_all_off_a: assert property ( // [RL7]
      @(posedge CLK) disable iff (RST)
      (STATE == ST_STOP && mode_reg == MODE_STOP) |-> !LSI_EN && !LSE_EN)
      else $error("low-speed source running in stop without clock");

   stop_wake_a: assert property ( // [RL10]
      @(posedge CLK) disable iff (RST)
      (STATE == ST_STOP && wake_stop) |-> ##[1:350] CPU_CLK_EN)
      else $error("stop wake too slow");

   stop_mask_a: assert property ( // [RL12]
      @(posedge CLK) disable iff (RST)
      (state_reg == ST_STOP && mode_reg == MODE_STOP && !gpio_s && ser_s == 4'h0)
      |=> (state_reg == ST_STOP))
      else $error("stop left on a masked source");

   stby_power_a: assert property ( // [RL13]
      @(posedge CLK) disable iff (RST)
      (STATE == ST_STBY) |-> REG_OFF && !CORE_PWR_EN && !RETAIN_EN)
      else $error("core still powered in standby");

   stby_reboot_a: assert property ( // [RL20]
      @(posedge CLK) disable iff (RST)
      ($past(STATE) == ST_STBY && STATE != ST_STBY) |-> CORE_RESET)
      else $error("standby left without core reset");

   lpslp_exit_a: assert property ( // [RL5]
      @(posedge CLK) disable iff (RST)
      (state_reg == ST_LPSLP && PERIPH_EVT) |=> CPU_CLK_EN && !REG_LP)
      else $error("low-power sleep wake kept low-power regulator");

   freq_gap_a: assert property ( // [RL19]
      @(posedge CLK) disable iff (RST)
      FREQ_ACK |-> (since_ack_reg >= GAP_W'(FREQ_GAP_CYC - 1)))
      else $error("frequency steps too close");

   freq_range_a: assert property ( // [RL1]
      @(posedge CLK) disable iff (RST)
      FREQ_ACK |-> (FREQ_KHZ <= FREQ_LIMIT_KHZ))
      else $error("frequency above range ceiling");
endmodule // lp_mode_ctrl

// File: testbench/wake_source_model.sv
// Purpose: peripheral, pin and reset sources facing the mode controller
// Assumes: one source bit per wake line, set by the bench
// Notes:   every line idles at its inactive level
`timescale 1ns/1ps
module wake_source_model (
   input  wire logic [14:0] src,       // 0 gpio,1-4 clock,5-8 serial,9-11 pin,12 rst,13 wdg,14 hsi
   output logic             evt_gpio,  // gpio event line
   output logic [3:0]       evt_rtc,   // alarm, tamper, stamp, periodic
   output logic [3:0]       evt_ser,   // serial and timer wakes
   output logic [2:0]       wake_pin,  // standby wake pins
   output logic             ext_rst_n, // reset pin, low active
   output logic             wdg_reset, // watchdog reset
   output logic             hsi_req    // peripheral borrowing fast rc
);
   // levels follow the bench; pins rest low so raising one is a clean edge
   always_comb begin
      evt_gpio  = src[0];
      evt_rtc   = src[4:1];
      evt_ser   = src[8:5];
      wake_pin  = src[11:9];
      ext_rst_n = ~src[12];
      wdg_reset = src[13];
      hsi_req   = src[14];
   end
endmodule // wake_source_model

// File: testbench/low_power_mode_controller_tb.sv
// Purpose: self-checking bench of the low-power mode controller
// Assumes: 100 MHz clock, inputs change 1 ns after the rising edge
// Notes:   core reset span shortened to 20 cycles to keep runs short
`timescale 1ns/1ps
module low_power_mode_controller_tb;
   import lpm_pkg::*;
   localparam int BOOT = 20;                        // shortened core reset span
   logic        clk, rst, sleep_req, periph_evt;    // clock, reset, cpu side
   logic        lp_run_req, lp_run_exit, msi_low;   // low-power run controls
   logic        low_supply, freq_req;               // frequency step controls
   logic [2:0]  mode_sel;                           // mode at request
   logic [1:0]  range_sel, ls_osc_on;               // range and slow osc enables
   logic [15:0] freq_new, cur;                      // requested and expected kHz
   logic [14:0] src;                                // wake source selector
   logic        evt_gpio, ext_rst_n, wdg_reset, hsi_req;
   logic [3:0]  evt_rtc, evt_ser;
   logic [2:0]  wake_pin;
   logic        cpu_clk_en, periph_clk_en, pll_en, msi_en, hsi_en, hse_byp_en;
   logic        lsi_en, lse_en, reg_lp, reg_off, core_pwr_en, retain_en, stby_keep;
   logic        core_reset, wake_irq, lp_run_act, freq_ack, freq_nak;
   logic [15:0] freq_limit_khz, freq_khz;
   lpm_state_t  state;
   logic        irq_seen, boot_seen;                // sticky wake markers
   int          error_cnt, comparisons;
   // clock and power enables packed for table compares, regulator lp at bit 4
   wire  [11:0] pwr = {cpu_clk_en, pll_en, msi_en, hsi_en, hse_byp_en, lsi_en, lse_en,
                       reg_lp, reg_off, core_pwr_en, retain_en, stby_keep};
   // per mode 1..4: expected pattern, compared bits, accepted wake sources
   logic [11:0] exp_v [1:4] = '{12'h076, 12'h016, 12'h069, 12'h009};
   logic [11:0] msk_v [1:4] = '{12'hFFF, 12'hFFF, 12'hFEF, 12'hF8F};
   logic [14:0] ok_m  [1:4] = '{15'h01FF, 15'h01E1, 15'h3E1E, 15'h3E00};

   lp_mode_ctrl #(.STBY_BOOT_CYC(BOOT)) u_dut (
      .CLK(clk), .RST(rst), .SLEEP_REQ(sleep_req), .MODE_SEL(mode_sel),
      .PERIPH_EVT(periph_evt), .LP_RUN_REQ(lp_run_req), .LP_RUN_EXIT(lp_run_exit),
      .MSI_LOW(msi_low), .RANGE_SEL(range_sel), .LS_OSC_ON(ls_osc_on),
      .LOW_SUPPLY(low_supply), .FREQ_REQ(freq_req), .FREQ_NEW(freq_new),
      .EVT_GPIO(evt_gpio), .EVT_RTC(evt_rtc), .EVT_SER(evt_ser), .WAKE_PIN(wake_pin),
      .EXT_RST_N(ext_rst_n), .WDG_RESET(wdg_reset), .HSI_REQ(hsi_req),
      .CPU_CLK_EN(cpu_clk_en), .PERIPH_CLK_EN(periph_clk_en), .PLL_EN(pll_en),
      .MSI_EN(msi_en), .HSI_EN(hsi_en), .HSE_BYP_EN(hse_byp_en), .LSI_EN(lsi_en),
      .LSE_EN(lse_en), .REG_LP(reg_lp), .REG_OFF(reg_off), .CORE_PWR_EN(core_pwr_en),
      .RETAIN_EN(retain_en), .STBY_KEEP(stby_keep), .CORE_RESET(core_reset),
      .WAKE_IRQ(wake_irq), .LP_RUN_ACT(lp_run_act), .FREQ_LIMIT_KHZ(freq_limit_khz),
      .FREQ_KHZ(freq_khz), .FREQ_ACK(freq_ack), .FREQ_NAK(freq_nak), .STATE(state));

   wake_source_model u_src (
      .src(src), .evt_gpio(evt_gpio), .evt_rtc(evt_rtc), .evt_ser(evt_ser),
      .wake_pin(wake_pin), .ext_rst_n(ext_rst_n), .wdg_reset(wdg_reset), .hsi_req(hsi_req));

   // free-running controller clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // one-cycle pulses are caught mid-cycle, where outputs have settled
   always @(negedge clk) begin
      if (wake_irq === 1'b1) irq_seen = 1'b1;
      if (core_reset === 1'b1) boot_seen = 1'b1;
   end

   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // request taken only in run, result visible one edge later
   task automatic enter(input logic [2:0] mode);
      mode_sel = mode;
      sleep_req = 1'b1;
      tick();
      sleep_req = 1'b0;
      tick();
   endtask

   // raise one source for six cycles and wait, bounded, for run
   task automatic wake(input int s, input int bound);
      int n;
      irq_seen = 1'b0;
      boot_seen = 1'b0;
      src = 15'(1) << s;
      for (n = 1; n <= bound && state !== ST_RUN; n++) begin
         tick();
         if (n == 6) src = '0;
      end
      src = '0;
      tick();
      chk(16'(state), 16'(ST_RUN), "back in run within bound");
      chk({15'h0, cpu_clk_en}, 16'h0001, "cpu clock back");
   endtask

   task automatic step(input logic [15:0] f, input logic ok);
      freq_new = f;
      freq_req = 1'b1;
      tick();
      freq_req = 1'b0;
      if (ok) cur = f;
      chk({14'h0, freq_ack, freq_nak}, ok ? 16'h0002 : 16'h0001, "step answer");
      chk(freq_khz, cur, "frequency");
      tick();
   endtask

   task automatic t_reset_ranges();
      logic [15:0] lim [4] = '{16'h7D00, 16'h3E80, 16'h1068, 16'h1068};
      chk({4'h0, pwr}, 16'h0FE4, "run enables after reset");
      chk(freq_khz, 16'h07D0, "reset frequency");
      for (int r = 0; r < 4; r++) begin
         range_sel = 2'(r + 1);
         tick(2);
         chk(freq_limit_khz, lim[r], "range ceiling");
      end
      range_sel = 2'd1;
      tick(2);
   endtask

   task automatic t_freq();
      cur = 16'h07D0;
      step(16'h0000, 1'b0);
      step(16'h80E8, 1'b0);
      tick(510);
      step(16'h1F40, 1'b1);
      step(16'h0FA0, 1'b0);
      tick(510);
      low_supply = 1'b1;
      step(16'h7D00, 1'b0);
      step(16'h7918, 1'b1);
      tick(510);
      step(16'h0083, 1'b1);
      low_supply = 1'b0;
   endtask

   task automatic t_sleep_lprun();
      enter(MODE_SLEEP);
      chk({14'h0, cpu_clk_en, periph_clk_en}, 16'h0001, "sleep clocks");
      enter(MODE_STOP_RTC);
      chk(16'(state), 16'(ST_SLEEP), "request outside run");
      periph_evt = 1'b1;
      tick();
      periph_evt = 1'b0;
      chk(16'(state), 16'(ST_RUN), "sleep wake");
      msi_low = 1'b1;
      lp_run_req = 1'b1;
      tick();
      lp_run_req = 1'b0;
      tick();
      chk({14'h0, lp_run_act, reg_lp}, 16'h0003, "low-power run");
      enter(MODE_SLEEP);
      chk(16'(state), 16'(ST_LPSLP), "low-power sleep");
      periph_evt = 1'b1;
      tick();
      periph_evt = 1'b0;
      chk({13'h0, state == ST_RUN, cpu_clk_en, reg_lp}, 16'h0006, "lp sleep wake");
      lp_run_exit = 1'b1;
      tick();
      lp_run_exit = 1'b0;
      msi_low = 1'b0;
      tick(2);
   endtask

   // every stop and standby mode against every wake source, reset and watchdog in standby only
   task automatic t_table();
      int f;
      for (int m = 1; m <= 4; m++) begin
         f = (m == 2) ? 0 : ((m == 1) ? 0 : 9);
         for (int s = 0; s < 14; s++) begin
            if (m < 3 && s > 11) continue;
            // wake pin already high before entry must not count as an edge
            if (m == 4 && s == 9) begin
               src = 15'h0200;
               tick(3);
            end
            enter(3'(m));
            chk(16'(state), (m < 3) ? 16'(ST_STOP) : 16'(ST_STBY), "entered");
            chk({4'h0, pwr & msk_v[m]}, {4'h0, exp_v[m]}, "enables");
            chk({14'h0, retain_en, stby_keep}, (m < 3) ? 16'h2 : 16'h1, "keep");
            if (m < 3 && s == 0) begin
               src = 15'h4000;
               tick(4);
               chk({15'h0, hsi_en}, 16'h0001, "fast rc lent");
               src = '0;
               tick(4);
            end
            if (m == 4 && s == 9) begin
               tick(20);
               chk(16'(state), 16'(ST_STBY), "held pin is no edge");
               src = '0;
               tick(3);
            end
            if (!ok_m[m][s]) begin
               src = 15'(1) << s;
               tick(20);
               chk(16'(state), (m < 3) ? 16'(ST_STOP) : 16'(ST_STBY), "ignored");
               src = '0;
               tick(3);
            end
            wake(ok_m[m][s] ? s : f, (m < 3) ? STOP_WAKE_CYC : STBY_EXIT_CYC);
            if (m < 3) begin
               chk({15'h0, irq_seen}, 16'h0001, "stop wake interrupt");
            end else begin
               chk({14'h0, boot_seen, lp_run_act}, 16'h0002, "core restarted");
               chk(freq_khz, 16'h07D0, "frequency after restart");
            end
         end
      end
   endtask

   // hang guard, well beyond the expected run length
   initial begin
      #400000;
      error_cnt++;
      end_sim();
   end

   initial begin
      {rst, sleep_req, periph_evt, lp_run_req, lp_run_exit, msi_low} = 6'b100000;
      {low_supply, freq_req, mode_sel, range_sel, ls_osc_on} = 9'b0_0_000_01_11;
      freq_new = 16'h0000;
      src = '0;
      {irq_seen, boot_seen, error_cnt, comparisons} = '0;
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      tick(3);
      t_reset_ranges();
      t_freq();
      t_sleep_lprun();
      t_table();
      end_sim();
   end
endmodule // low_power_mode_controller_tb
